// ==== design/mcr_pkg.sv ====
// shared constants for the counter indirect read path
package mcr_pkg;
  // device register map on the management link
  localparam logic [7:0] REG_TABLE_SEL = 8'h79;
  localparam logic [7:0] REG_TRIGGER   = 8'h7a;
  localparam logic [7:0] REG_DATA_TOP  = 8'h80;
  localparam logic [7:0] REG_DATA_B2   = 8'h81;
  localparam logic [7:0] REG_DATA_B1   = 8'h82;
  localparam logic [7:0] REG_DATA_B0   = 8'h83;
  // table select codes
  localparam logic [7:0] SEL_PORT_TABLE = 8'h1c;
  localparam logic [7:0] SEL_DROP_TABLE = 8'h1d;
  // counter layout
  localparam int PORT_COUNT    = 3;
  localparam int CNT_PER_PORT  = 32;
  localparam int PORT_CNT_W    = 30;
  localparam int DROP_COUNT    = 6;
  localparam int DROP_CNT_W    = 16;
  localparam logic [7:0] PORT_BASE_STEP = 8'h20;
  localparam logic [7:0] DROP_TX_FIRST  = 8'h00;
  localparam logic [7:0] DROP_RX_FIRST  = 8'h03;
  localparam int FLAG_OVF_BIT   = 7;
  localparam int FLAG_VALID_BIT = 6;
  localparam int FETCH_CYCLES   = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // host command registers on the software port
  localparam logic [3:0] HREG_CTRL     = 4'h0;
  localparam logic [3:0] HREG_OFFSET   = 4'h1;
  localparam logic [3:0] HREG_STATUS   = 4'h2;
  localparam logic [3:0] HREG_VALUE    = 4'h3;
  localparam logic [3:0] HREG_INT_STAT = 4'h4;
  localparam logic [3:0] HREG_INT_MASK = 4'h5;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DROP_BIT  = 1;
  localparam int INT_DONE_BIT   = 0;
  localparam int INT_OVF_BIT    = 1;
  localparam int INT_STALE_BIT  = 2;
  localparam int INT_W          = 3;
  // refresh interval the host should keep
  localparam longint POLL_INTERVAL_S  = 30;
  localparam longint CLK_HZ           = 125000000;
  localparam longint POLL_CYCLES      = POLL_INTERVAL_S * CLK_HZ;
endpackage

// ==== design/mcr_link_if.sv ====
// byte-wide management register link between host and device
`timescale 1ns/1ps
interface mcr_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  modport host (output addr, output wdata, output wr, output rd, input rdata);
  modport dev  (input addr, input wdata, input wr, input rd, output rdata);
endinterface

// ==== design/mcr_device.sv ====
// device end: counter store with indirect read registers
// Function
// - host selects per-port table with 0x1c
// - offset write starts fetch into data
// - port two offsets add port base
// - each port owns 32 offsets
// - overflow flag in bit 31
// - valid flag bit 30, host rereads
// - value most significant first, low last
// - host selects drop table with 0x1d
// - drop value in third, fourth bytes
// - six drop counters, tx then rx
// - per-port counters clear when read
// - drop counters keep value when read
// - drop reads carry no flags
// - host raises stale interrupt after 30 seconds with no completed read
`timescale 1ns/1ps
module mcr_device
  import mcr_pkg::*;
(
  input  wire logic                             clk,
  input  wire logic                             resetn,
  mcr_link_if.dev                               link,
  input  wire logic [PORT_COUNT*CNT_PER_PORT-1:0] portInc,
  input  wire logic [DROP_COUNT-1:0]            dropInc,
  output logic                                  fetchBusy
);
  localparam int NPORT = PORT_COUNT * CNT_PER_PORT;

  logic [7:0]            tableSel_reg;
  logic [7:0]            trigger_reg;
  logic [7:0]            dataByte_reg [4];
  logic [7:0]            rdata_reg;
  logic [1:0]            fetchCnt_reg;
  logic                  fetchBusy_reg;
  logic [PORT_CNT_W-1:0] portCnt_reg   [NPORT];
  logic                  portOvf_reg   [NPORT];
  logic [DROP_CNT_W-1:0] dropCnt_reg   [DROP_COUNT];
  logic [PORT_CNT_W-1:0] portCnt_next  [NPORT];
  logic                  portOvf_next  [NPORT];
  logic [DROP_CNT_W-1:0] dropCnt_next  [DROP_COUNT];

  // register decode
  wire wrSel     = link.wr && (link.addr == REG_TABLE_SEL);
  wire wrTrig    = link.wr && (link.addr == REG_TRIGGER);
  wire isPortSel = (tableSel_reg == SEL_PORT_TABLE);
  wire isDropSel = (tableSel_reg == SEL_DROP_TABLE);
  // port field is trigger[6:5], counter field trigger[4:0]
  wire [6:0] portIdx   = trigger_reg[6:0];
  wire       portInRng = (trigger_reg < 8'(NPORT));
  wire       dropInRng = (trigger_reg < 8'(DROP_COUNT));
  wire [2:0] dropIdx   = trigger_reg[2:0];
  wire       fetchDone = fetchBusy_reg && (fetchCnt_reg == 2'(FETCH_CYCLES - 1));
  wire       clearHit  = fetchDone && isPortSel && portInRng;

  wire [PORT_CNT_W-1:0] selPortVal = portInRng ? portCnt_reg[portIdx] : '0;
  wire                  selPortOvf = portInRng ? portOvf_reg[portIdx] : 1'b0;
  wire [DROP_CNT_W-1:0] selDropVal = dropInRng ? dropCnt_reg[dropIdx] : '0;

  wire [7:0] rdMux =
    (link.addr == REG_TABLE_SEL) ? tableSel_reg :
    (link.addr == REG_TRIGGER)   ? trigger_reg :
    (link.addr == REG_DATA_TOP)  ? dataByte_reg[0] :
    (link.addr == REG_DATA_B2)   ? dataByte_reg[1] :
    (link.addr == REG_DATA_B1)   ? dataByte_reg[2] :
    (link.addr == REG_DATA_B0)   ? dataByte_reg[3] : RESET_BYTE;

  assign link.rdata = rdata_reg;
  assign fetchBusy  = fetchBusy_reg;

  // counter next values; an event in the clearing cycle still counts
  always_comb
  begin
    for (int i = 0; i < NPORT; i++)
    begin
      portCnt_next[i] = portCnt_reg[i] + PORT_CNT_W'(portInc[i]);
      portOvf_next[i] = portOvf_reg[i] || (portInc[i] && (&portCnt_reg[i]));
      if (clearHit && (portIdx == 7'(i)))
      begin
        portCnt_next[i] = PORT_CNT_W'(portInc[i]);
        portOvf_next[i] = 1'b0;
      end
    end
    for (int j = 0; j < DROP_COUNT; j++)
    begin
      dropCnt_next[j] = dropCnt_reg[j] + DROP_CNT_W'(dropInc[j]);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NPORT; i++)
      begin
        portCnt_reg[i] <= '0;
        portOvf_reg[i] <= 1'b0;
      end
      for (int j = 0; j < DROP_COUNT; j++)
      begin
        dropCnt_reg[j] <= '0;
      end
    end
    else
    begin
      portCnt_reg <= portCnt_next;
      portOvf_reg <= portOvf_next;
      dropCnt_reg <= dropCnt_next;
    end
  end

  // control registers and read data
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tableSel_reg <= RESET_BYTE;
      trigger_reg  <= RESET_BYTE;
      rdata_reg    <= RESET_BYTE;
    end
    else
    begin
      if (wrSel)
        tableSel_reg <= link.wdata;
      if (wrTrig)
        trigger_reg <= link.wdata;
      rdata_reg <= link.rd ? rdMux : RESET_BYTE;
    end
  end

  // fetch sequencer; a new trigger restarts the copy
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fetchBusy_reg <= 1'b0;
      fetchCnt_reg  <= '0;
    end
    else if (wrTrig)
    begin
      fetchBusy_reg <= 1'b1;
      fetchCnt_reg  <= '0;
    end
    else if (fetchDone)
    begin
      fetchBusy_reg <= 1'b0;
    end
    else if (fetchBusy_reg)
    begin
      fetchCnt_reg <= fetchCnt_reg + 2'd1;
    end
  end

  // data bytes: valid cleared on trigger, set when a non-drop copy lands
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int k = 0; k < 4; k++)
      begin
        dataByte_reg[k] <= RESET_BYTE;
      end
    end
    else if (wrTrig)
    begin
      dataByte_reg[0][FLAG_VALID_BIT] <= 1'b0;
    end
    else if (fetchDone && isDropSel)
    begin
      dataByte_reg[0] <= RESET_BYTE;
      dataByte_reg[1] <= RESET_BYTE;
      dataByte_reg[2] <= selDropVal[15:8];
      dataByte_reg[3] <= selDropVal[7:0];
    end
    else if (fetchDone)
    begin
      dataByte_reg[0] <= {selPortOvf, 1'b1, selPortVal[29:24]};
      dataByte_reg[1] <= selPortVal[23:16];
      dataByte_reg[2] <= selPortVal[15:8];
      dataByte_reg[3] <= selPortVal[7:0];
    end
  end
endmodule

// ==== design/mcr_host.sv ====
// host end: runs indirect counter reads for software
`timescale 1ns/1ps
module mcr_host
  import mcr_pkg::*;
#(
  parameter longint POLL_LIMIT = POLL_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  mcr_link_if.host         link,
  input  wire logic [3:0]  swAddr,
  input  wire logic [31:0] swWdata,
  input  wire logic        swWr,
  input  wire logic        swRd,
  output logic [31:0]      swRdata,
  output logic             irq
);
  typedef enum {ST_IDLE, ST_SEL, ST_TRIG, ST_RD, ST_WAIT, ST_CHK, ST_DONE} mcr_state_e;

  mcr_state_e  state_reg;
  logic [7:0]  offset_reg;
  logic        dropMode_reg;
  logic [1:0]  byteIdx_reg;
  logic [1:0]  waitCnt_reg;
  logic [31:0] value_reg;
  logic        lastOvf_reg;
  logic [INT_W-1:0] intStat_reg;
  logic [INT_W-1:0] intMask_reg;
  logic [31:0] swRdata_reg;
  logic        irq_reg;
  logic [63:0] pollCnt_reg;
  logic [7:0]  lAddr_reg;
  logic [7:0]  lWdata_reg;
  logic        lWr_reg;
  logic        lRd_reg;

  wire swCtrlWr  = swWr && (swAddr == HREG_CTRL);
  wire startReq  = swCtrlWr && swWdata[CTRL_START_BIT] && (state_reg == ST_IDLE);
  wire lastByte  = (byteIdx_reg == 2'd3);
  wire flagsByte = !dropMode_reg && (byteIdx_reg == 2'd0);
  wire notValid  = flagsByte && !link.rdata[FLAG_VALID_BIT];
  wire doneEv    = (state_reg == ST_CHK) && !notValid && lastByte;
  wire ovfEv     = doneEv && lastOvf_reg;
  wire staleEv   = (pollCnt_reg == 64'(POLL_LIMIT - 1));
  wire [INT_W-1:0] intSet = {staleEv, ovfEv, doneEv};
  wire [INT_W-1:0] intClr = (swWr && (swAddr == HREG_INT_STAT)) ? swWdata[INT_W-1:0] : '0;
  wire [7:0] rdAddr  = REG_DATA_TOP + {6'h00, byteIdx_reg};
  wire [31:0] rdMux =
    (swAddr == HREG_CTRL)     ? {30'h0, dropMode_reg, 1'b0} :
    (swAddr == HREG_OFFSET)   ? {24'h0, offset_reg} :
    (swAddr == HREG_STATUS)   ? {30'h0, lastOvf_reg, state_reg != ST_IDLE} :
    (swAddr == HREG_VALUE)    ? value_reg :
    (swAddr == HREG_INT_STAT) ? {29'h0, intStat_reg} :
    (swAddr == HREG_INT_MASK) ? {29'h0, intMask_reg} : 32'h0;

  assign link.addr  = lAddr_reg;
  assign link.wdata = lWdata_reg;
  assign link.wr    = lWr_reg;
  assign link.rd    = lRd_reg;
  assign swRdata    = swRdata_reg;
  assign irq        = irq_reg;

  // software registers and interrupt
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      offset_reg   <= 8'h00;
      dropMode_reg <= 1'b0;
      intStat_reg  <= '0;
      intMask_reg  <= '0;
      swRdata_reg  <= 32'h0;
      irq_reg      <= 1'b0;
    end
    else
    begin
      if (swWr && (swAddr == HREG_OFFSET) && (state_reg == ST_IDLE))
        offset_reg <= swWdata[7:0];
      if (startReq)
        dropMode_reg <= swWdata[CTRL_DROP_BIT];
      if (swWr && (swAddr == HREG_INT_MASK))
        intMask_reg <= swWdata[INT_W-1:0];
      intStat_reg <= (intStat_reg & ~intClr) | intSet;
      swRdata_reg <= swRd ? rdMux : 32'h0;
      irq_reg     <= |(((intStat_reg & ~intClr) | intSet) & intMask_reg);
    end
  end

  // time since last completed read or stale event
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pollCnt_reg <= 64'h0;
    else if (doneEv || staleEv)
      pollCnt_reg <= 64'h0;
    else
      pollCnt_reg <= pollCnt_reg + 64'h1;
  end

  // link sequencer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg   <= ST_IDLE;
      byteIdx_reg <= 2'd0;
      waitCnt_reg <= 2'd0;
      value_reg   <= 32'h0;
      lastOvf_reg <= 1'b0;
      lAddr_reg   <= 8'h00;
      lWdata_reg  <= 8'h00;
      lWr_reg     <= 1'b0;
      lRd_reg     <= 1'b0;
    end
    else
    begin
      lWr_reg <= 1'b0;
      lRd_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE:
        begin
          if (startReq)
          begin
            lAddr_reg  <= REG_TABLE_SEL;
            lWdata_reg <= swWdata[CTRL_DROP_BIT] ? SEL_DROP_TABLE : SEL_PORT_TABLE;
            lWr_reg    <= 1'b1;
            state_reg  <= ST_SEL;
          end
        end
        ST_SEL:
        begin
          lAddr_reg  <= REG_TRIGGER;
          lWdata_reg <= offset_reg;
          lWr_reg    <= 1'b1;
          byteIdx_reg <= dropMode_reg ? 2'd2 : 2'd0;
          // drop reads carry no valid flag, so wait out the copy
          waitCnt_reg <= dropMode_reg ? 2'(FETCH_CYCLES) : 2'd0;
          value_reg  <= 32'h0;
          state_reg  <= ST_TRIG;
        end
        ST_TRIG:
        begin
          if (waitCnt_reg != 2'd0)
            waitCnt_reg <= waitCnt_reg - 2'd1;
          else
          begin
            lAddr_reg <= rdAddr;
            lRd_reg   <= 1'b1;
            state_reg <= ST_WAIT;
          end
        end
        ST_RD:
        begin
          lAddr_reg <= rdAddr;
          lRd_reg   <= 1'b1;
          state_reg <= ST_WAIT;
        end
        // answer is registered: it stands the cycle after the read
        ST_WAIT:
          state_reg <= ST_CHK;
        ST_CHK:
        begin
          if (notValid)
            byteIdx_reg <= 2'd0;
          else
          begin
            if (flagsByte)
            begin
              lastOvf_reg <= link.rdata[FLAG_OVF_BIT];
              value_reg   <= {24'h0, 2'b00, link.rdata[5:0]};
            end
            else
              value_reg <= {value_reg[23:0], link.rdata};
            if (dropMode_reg && byteIdx_reg == 2'd2)
              lastOvf_reg <= 1'b0;
            byteIdx_reg <= byteIdx_reg + 2'd1;
          end
          state_reg <= (!notValid && lastByte) ? ST_DONE : ST_RD;
        end
        ST_DONE:
          state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// ==== tb/mcr_link_monitor.sv ====
// link checker for the counter indirect read path
`timescale 1ns/1ps
module mcr_link_monitor
  import mcr_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  wire trig  = wr && addr == REG_TRIGGER;
  wire rdTop = rd && addr == REG_DATA_TOP;

  property p_idle_zero;
    !rd |=> rdata == 8'h00;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("link data not zero outside a read answer");
  property p_one_strobe;
    !(wr && rd);
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("write and read strobes together");
  property p_sel_code;
    wr && addr == REG_TABLE_SEL |-> wdata == SEL_PORT_TABLE || wdata == SEL_DROP_TABLE;
  endproperty
  a_sel_code: assert property (p_sel_code)
    else $error("bad table select code");
  property p_sel_first;
    trig |-> $past(wr) && $past(addr) == REG_TABLE_SEL;
  endproperty
  a_sel_first: assert property (p_sel_first)
    else $error("trigger without table select before it");
  property p_no_data_write;
    wr |-> addr == REG_TABLE_SEL || addr == REG_TRIGGER;
  endproperty
  a_no_data_write: assert property (p_no_data_write)
    else $error("write to a place other than select or trigger");
  property p_valid_late;
    trig ##1 rdTop |=> !rdata[FLAG_VALID_BIT];
  endproperty
  a_valid_late: assert property (p_valid_late)
    else $error("valid flag high before copy done");
  property p_reread;
    rdTop ##1 !rdata[FLAG_VALID_BIT] |-> ##[1:3] rdTop;
  endproperty
  a_reread: assert property (p_reread)
    else $error("no reread of top byte after invalid");
  property p_low_order;
    rd && addr == REG_DATA_B0 |-> $past(rd, 3) && $past(addr, 3) == REG_DATA_B1;
  endproperty
  a_low_order: assert property (p_low_order)
    else $error("low byte not read after third byte");
  c_reread: cover property (rdTop ##1 !rdata[FLAG_VALID_BIT]);
  c_drop: cover property (wr && addr == REG_TABLE_SEL && wdata == SEL_DROP_TABLE);
  c_trig_read: cover property (trig ##1 rdTop);
endmodule

// ==== tb/tb.sv ====
// testbench for host and device joined over the link
`timescale 1ns/1ps
module tb
  import mcr_pkg::*;
;
  localparam int PW = PORT_COUNT * CNT_PER_PORT;
  logic          clk         = 1'b0;
  logic          resetn      = 1'b0;
  logic [PW-1:0] portInc     = '0;
  logic [5:0]    dropInc     = '0;
  logic [3:0]    swAddr      = '0;
  logic [31:0]   swWdata     = '0;
  logic          swWr        = 1'b0;
  logic          swRd        = 1'b0;
  logic          rdA         = 1'b0;
  logic [31:0]   rnd         = 32'h9e2b;
  logic [31:0]   swRdata;
  logic          irq;
  logic          fetchBusy;
  logic [31:0]   expQ[$];
  int            errors      = 0;
  int            checks_done = 0;
  int            cycles      = 0;

  always #4 clk = ~clk;
  mcr_link_if link();
  mcr_device mcr_device_i (.clk(clk), .resetn(resetn), .link(link.dev), .portInc(portInc),
    .dropInc(dropInc), .fetchBusy(fetchBusy));
  mcr_host #(.POLL_LIMIT(1000)) mcr_host_i (.clk(clk), .resetn(resetn), .link(link.host),
    .swAddr(swAddr), .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata), .irq(irq));
  mcr_link_monitor mcr_link_monitor_i (.clk(clk), .resetn(resetn), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    swAddr  <= a;
    swWdata <= d;
    swWr    <= 1'b1;
    @(posedge clk);
    swWr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    swAddr <= a;
    swRd   <= 1'b1;
    expQ.push_back(exp);
    @(posedge clk);
    swRd   <= 1'b0;
  endtask
  task automatic bump(input int idx, input logic [31:0] n, input logic drop);
    repeat (n)
    begin
      @(posedge clk);
      portInc <= drop ? '0 : PW'(1) << idx;
      dropInc <= drop ? 6'(1) << idx : '0;
      @(posedge clk);
      portInc <= '0;
      dropInc <= '0;
    end
  endtask
  // start a read, write a stray offset while busy, wait for done and clear it
  task automatic fetch(input logic [7:0] off, input logic drop, input logic [31:0] exp);
    int n;
    n = 0;
    wr_reg(HREG_OFFSET, {24'h0, off});
    wr_reg(HREG_CTRL, {30'h0, drop, 1'b1});
    wr_reg(HREG_OFFSET, 32'h0);
    while (irq !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, fetchBusy}, 32'h0);
    rd_reg(HREG_VALUE, exp);
    rd_reg(HREG_INT_STAT, 32'h1);
    rd_reg(HREG_OFFSET, {24'h0, off});
    rd_reg(HREG_CTRL, {30'h0, drop, 1'b0});
    rd_reg(HREG_STATUS, 32'h0);
    wr_reg(HREG_INT_STAT, 32'h1);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
  endtask

  always @(posedge clk)
  begin
    rdA    <= swRd;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      give_verdict();
    end
  end
  always @(negedge clk)
    if (rdA && expQ.size() > 0)
      chk(swRdata, expQ.pop_front());

  initial
  begin
    logic [31:0] n;
    logic [7:0]  off;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd_reg(HREG_INT_MASK, 32'h0);
    rd_reg(HREG_STATUS, 32'h0);
    rd_reg(4'hf, 32'h0);
    wr_reg(HREG_INT_MASK, 32'h1);
    for (int p = 0; p < PORT_COUNT; p++)
    begin
      rnd = lfsr(rnd);
      n = {28'h0, rnd[3:0]} + 32'h1;
      off = PORT_BASE_STEP * 8'(p) + ((p == 2) ? 8'h1f : 8'h0e);
      bump(int'(off), n, 1'b0);
      fetch(off, 1'b0, n);
      fetch(off, 1'b0, 32'h0);
    end
    fetch(8'(PW), 1'b0, 32'h0);
    for (int k = 0; k < DROP_COUNT; k++)
    begin
      rnd = lfsr(rnd);
      n = {28'h0, rnd[3:0]} + 32'h1;
      bump(k, n, 1'b1);
      fetch(DROP_TX_FIRST + 8'(k), 1'b1, n);
      fetch(DROP_TX_FIRST + 8'(k), 1'b1, n);
    end
    rd_reg(HREG_STATUS, 32'h0);
    wr_reg(HREG_INT_MASK, 32'h4);
    repeat (1100) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h1);
    rd_reg(HREG_INT_STAT, 32'h4);
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule
